/* core/sep_pkg.sv */
//==========================================================
// Purpose: shared constants for the serial eeprom read path
// Assumes: 20 MHz system clock on both ends
// Notes:   link clock is sampled, never used as a clock
package sep_pkg;
  localparam int        ADDR_W       = 15;
  localparam int        PAGE_BITS    = 6;
  localparam int        BYTE_W       = 8;
  localparam int        DEPTH        = 32768;
  localparam logic [3:0] TYPE_CODE   = 4'h5;  // arbitrary device-type value
  localparam logic [14:0] ADDR_TOP   = 15'h7FFF;
  localparam logic [14:0] ADDR_BOTTOM = 15'h0000;
  localparam int        CLK_MHZ      = 20;
  localparam int        WRITE_US     = 50;    // internal write time, shortened default
  localparam int        WRITE_CYC    = WRITE_US * CLK_MHZ;
  localparam int        HALF_CYC     = 4;     // link clock quarter period in clocks
  localparam int        CNT_W        = 16;
endpackage

/* core/sep_link_if.sv */
//==========================================================
// Purpose: two-wire link joining host and device
// Assumes: open-drain wires, pull-up resolved here
// Notes:   output enable low means the end drives low
`timescale 1ns/100ps
interface sep_link_if;
  logic scl_o_host;
  logic scl_oe_n_host;
  logic sda_o_host;
  logic sda_oe_n_host;
  logic sda_o_dev;
  logic sda_oe_n_dev;
  logic scl;
  logic sda;
  assign scl = ~(~scl_oe_n_host & ~scl_o_host);
  assign sda = ~((~sda_oe_n_host & ~sda_o_host) | (~sda_oe_n_dev & ~sda_o_dev));
  modport host (output scl_o_host, output scl_oe_n_host, output sda_o_host,
                output sda_oe_n_host, input scl, input sda);
  modport dev  (output sda_o_dev, output sda_oe_n_dev, input scl, input sda);
endinterface

/* core/sep_dev.sv */
//==========================================================
// Purpose: device end of the serial eeprom, read and ack-poll path
// Assumes: link clock and data sampled through two flops
// Notes:   array is flops; writes store the last data byte only
//
// How it works
// - busy write cycle withholds control-byte ack
// - stop after write starts write cycle
// - host may poll right after stop
// - poll is start plus write control byte
// - unacked poll is repeated by host
// - finished cycle acks the poll
// - read selected by read/write bit one
// - counter holds last address plus one
// - read control acked, byte shifted out
// - nack then stop ends single read
// - random read loads address without data
// - repeated start keeps pointer, no write
// - read control after restart returns loaded byte
// - after random read pointer is next
// - host ack fetches next byte
// - host ends sequential read with nack
// - pointer increments after every read byte, once per write at stop
// - pointer wraps from top to zero
// - respond only to matching code and selects
// - address sent high byte first, 15 bits
// - nack releases data line high
`timescale 1ns/100ps
module sep_dev #(
  parameter int WRITE_CYCLES = sep_pkg::WRITE_CYC
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // chip select straps
  input  wire logic       i_chip_select_bit_zero,
  input  wire logic       i_chip_select_bit_one,
  input  wire logic       i_chip_select_bit_two,
  // status
  output logic            o_busy,
  // link
  sep_link_if.dev         link
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_CTRL = 3'b001, ST_ADDRH = 3'b010, ST_ADDRL = 3'b011,
    ST_WDATA = 3'b100, ST_READ = 3'b101, ST_RACK = 3'b110
  } sep_dst_e;

  //==========================================================
  // input synchronisers and edges
  logic [1:0] scl_s_r, sda_s_r;
  logic       scl_d_r, sda_d_r;
  always_ff @(posedge i_clk)
  begin
    scl_s_r <= {scl_s_r[0], link.scl};
    sda_s_r <= {sda_s_r[0], link.sda};
    scl_d_r <= scl_s_r[1];
    sda_d_r <= sda_s_r[1];
  end
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s_r[1] & ~scl_d_r;
  assign scl_fall = ~scl_s_r[1] & scl_d_r;
  assign start_c  = scl_s_r[1] & scl_d_r & ~sda_s_r[1] & sda_d_r;
  assign stop_c   = scl_s_r[1] & scl_d_r & sda_s_r[1] & ~sda_d_r;

  //==========================================================
  // byte engine
  sep_dst_e              st_r;
  logic [3:0]            bit_r;
  logic [7:0]            sh_r;
  logic                  ack_r;   // driving ack low in ninth slot
  logic                  tx_r;    // transmitting read byte
  logic                  wr_pend_r;
  logic [14:0]           ptr_r;
  logic [7:0]            ahi_r;
  localparam int CNT_W_L = sep_pkg::CNT_W;
  logic [7:0]            wdat_r;
  logic [CNT_W_L-1:0]    busy_cnt_r;
  logic [7:0]            mem_r [sep_pkg::DEPTH];
  logic [2:0]            sel;
  assign sel = {i_chip_select_bit_two, i_chip_select_bit_one, i_chip_select_bit_zero};

  function automatic logic [14:0] nxt_addr(input logic [14:0] a);
    nxt_addr = (a == sep_pkg::ADDR_TOP) ? sep_pkg::ADDR_BOTTOM : a + 15'h0001;
  endfunction

  logic [7:0] rx_byte;
  assign rx_byte = {sh_r[6:0], sda_s_r[1]};
  assign o_busy  = (busy_cnt_r != '0);

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st_r <= ST_IDLE; bit_r <= 4'h0; sh_r <= 8'h00; ack_r <= 1'b0; tx_r <= 1'b0;
      wr_pend_r <= 1'b0; ptr_r <= 15'h0000; ahi_r <= 8'h00; wdat_r <= 8'h00;
    end
    else if (start_c)
    begin
      // repeated start ends a write with no data written
      st_r <= ST_CTRL; bit_r <= 4'h0; ack_r <= 1'b0; tx_r <= 1'b0;
      wr_pend_r <= 1'b0;
    end
    else if (stop_c)
    begin
      st_r <= ST_IDLE; ack_r <= 1'b0; tx_r <= 1'b0;
      if (wr_pend_r)
      begin
        mem_r[ptr_r] <= wdat_r;
        ptr_r        <= nxt_addr(ptr_r);
        wr_pend_r    <= 1'b0;
      end
    end
    else if (scl_rise && st_r != ST_IDLE && !tx_r && !ack_r && bit_r < 4'd8)
    begin
      sh_r  <= rx_byte;
      bit_r <= bit_r + 4'h1;
    end
    else if (scl_rise && st_r == ST_RACK && bit_r == 4'd8)
    begin
      // every finished byte moves the pointer, acked or not
      ptr_r <= nxt_addr(ptr_r);
      if (!sda_s_r[1])
        st_r <= ST_READ;
      else
        st_r <= ST_IDLE;
      bit_r <= 4'h0;
    end
    else if (scl_rise && tx_r)
      bit_r <= bit_r + 4'h1;
    else if (scl_fall)
    begin
      if (ack_r)
      begin
        ack_r <= 1'b0;
        bit_r <= 4'h0;
        if (st_r == ST_READ)
        begin
          tx_r <= 1'b1;
          sh_r <= mem_r[ptr_r];
        end
      end
      else if (tx_r && bit_r == 4'd8)
      begin
        tx_r  <= 1'b0;
        st_r  <= ST_RACK;
      end
      else if (tx_r)
        sh_r <= {sh_r[6:0], 1'b1};
      else if (st_r == ST_READ && !tx_r && bit_r == 4'd0)
      begin
        tx_r <= 1'b1;
        sh_r <= mem_r[ptr_r];
      end
      else if (bit_r == 4'd8)
      begin
        unique case (st_r)
          ST_CTRL:
          begin
            if (sh_r[7:4] == sep_pkg::TYPE_CODE && sh_r[3:1] == sel && !o_busy)
            begin
              ack_r <= 1'b1;
              st_r  <= sh_r[0] ? ST_READ : ST_ADDRH;
            end
            else
              st_r <= ST_IDLE;
          end
          ST_ADDRH:
          begin
            ahi_r <= sh_r; ack_r <= 1'b1; st_r <= ST_ADDRL;
          end
          ST_ADDRL:
          begin
            ptr_r <= {ahi_r[6:0], sh_r}; ack_r <= 1'b1; st_r <= ST_WDATA;
          end
          ST_WDATA:
          begin
            wdat_r <= sh_r; wr_pend_r <= 1'b1; ack_r <= 1'b1;
          end
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end

  //==========================================================
  // internally timed write cycle
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      busy_cnt_r <= '0;
    else if (stop_c && wr_pend_r)
      busy_cnt_r <= CNT_W_L'(WRITE_CYCLES);
    else if (busy_cnt_r != '0)
      busy_cnt_r <= busy_cnt_r - 1'b1;
  end

  //==========================================================
  // data line drive
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      link.sda_oe_n_dev <= 1'b1;
    else
      // last bit held until the clock falls, never moved while clock high
      link.sda_oe_n_dev <= ~(ack_r | (tx_r & ~sh_r[7]));
  end
  assign link.sda_o_dev = 1'b0;
endmodule

/* core/sep_host.sv */
//==========================================================
// Purpose: host end issuing polls and reads
// Assumes: single command at a time
// Notes:   makes the link clock by dividing its own clock
`timescale 1ns/100ps
module sep_host #(
  parameter int HALF = sep_pkg::HALF_CYC
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // command
  input  wire logic        i_go,
  input  wire logic [1:0]  i_op,     // 0 poll, 1 current read, 2 random read, 3 write byte
  input  wire logic [2:0]  i_sel,
  input  wire logic [14:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic [7:0]  i_count,  // bytes to read
  output logic             o_ready,
  output logic             o_rvalid,
  output logic [7:0]       o_rdata,
  output logic             o_nack,
  // link
  sep_link_if.host         link
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_START = 3'b001, H_BYTE = 3'b010, H_ACK = 3'b011,
    H_RBYTE = 3'b100, H_MACK = 3'b101, H_STOP = 3'b110
  } sep_hst_e;
  sep_hst_e st_r;
  logic [1:0] sda_s_r;
  always_ff @(posedge i_clk) sda_s_r <= {sda_s_r[0], link.sda};
  logic [7:0]  cnt_r, sh_r, left_r;
  logic [3:0]  bit_r;
  logic [1:0]  ph_r;   // quarter of a link bit
  logic [2:0]  idx_r;  // which byte of the command
  logic        rd_r, scl_r, sda_r;
  logic [1:0]  op_r;
  logic        tick;
  assign tick = (cnt_r == 8'(HALF - 1));
  assign o_ready = (st_r == H_IDLE);
  assign link.scl_o_host = 1'b0;
  assign link.sda_o_host = 1'b0;
  assign link.scl_oe_n_host = scl_r;
  assign link.sda_oe_n_host = sda_r;

  function automatic logic [7:0] cmd_byte(input logic [2:0] i, input logic rd);
    unique case (i)
      3'd0:    cmd_byte = {sep_pkg::TYPE_CODE, i_sel, rd};
      3'd1:    cmd_byte = {1'b0, i_addr[14:8]};
      3'd2:    cmd_byte = i_addr[7:0];
      default: cmd_byte = i_wdata;
    endcase
  endfunction

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st_r <= H_IDLE; cnt_r <= 8'h00; bit_r <= 4'h0; ph_r <= 2'd0; idx_r <= 3'd0;
      rd_r <= 1'b0; scl_r <= 1'b1; sda_r <= 1'b1; op_r <= 2'd0; sh_r <= 8'h00;
      left_r <= 8'h00; o_rvalid <= 1'b0; o_rdata <= 8'h00; o_nack <= 1'b0;
    end
    else
    begin
      o_rvalid <= 1'b0;
      cnt_r <= tick ? 8'h00 : cnt_r + 8'h01;
      if (st_r == H_IDLE)
      begin
        cnt_r <= 8'h00;
        if (i_go)
        begin
          op_r <= i_op; rd_r <= (i_op == 2'd1); idx_r <= 3'd0; o_nack <= 1'b0;
          left_r <= i_count; st_r <= H_START; ph_r <= 2'd0;
        end
      end
      else if (tick)
      begin
        ph_r <= ph_r + 2'd1;
        unique case (st_r)
          H_START:
          begin
            // data released first so a restart never races the clock edge
            if (ph_r == 2'd0) sda_r <= 1'b1;
            if (ph_r == 2'd1) scl_r <= 1'b1;
            if (ph_r == 2'd2) sda_r <= 1'b0;
            if (ph_r == 2'd3)
            begin
              scl_r <= 1'b0; sh_r <= cmd_byte(idx_r, rd_r); bit_r <= 4'h0; st_r <= H_BYTE;
              ph_r <= 2'd0;
            end
          end
          H_BYTE, H_ACK, H_RBYTE, H_MACK:
          begin
            if (ph_r == 2'd0)
            begin
              if (st_r == H_BYTE) sda_r <= sh_r[7];
              else if (st_r == H_MACK) sda_r <= (left_r == 8'h01);
              else sda_r <= 1'b1;
            end
            if (ph_r == 2'd1) scl_r <= 1'b1;
            if (ph_r == 2'd2)
            begin
              if (st_r == H_RBYTE) sh_r <= {sh_r[6:0], sda_s_r[1]};
              if (st_r == H_ACK && sda_s_r[1] && idx_r == 3'd0) o_nack <= 1'b1;
            end
            if (ph_r == 2'd3)
            begin
              scl_r <= 1'b0;
              bit_r <= bit_r + 4'h1;
              if (st_r == H_BYTE)
              begin
                sh_r <= {sh_r[6:0], 1'b0};
                if (bit_r == 4'd7) st_r <= H_ACK;
              end
              else if (st_r == H_RBYTE)
              begin
                if (bit_r == 4'd7) begin st_r <= H_MACK; o_rdata <= sh_r; o_rvalid <= 1'b1; end
              end
              else if (st_r == H_MACK)
              begin
                left_r <= left_r - 8'h01; bit_r <= 4'h0;
                st_r   <= (left_r == 8'h01) ? H_STOP : H_RBYTE;
              end
              else
              begin
                bit_r <= 4'h0;
                if (o_nack) st_r <= H_STOP;
                else if (rd_r) st_r <= H_RBYTE;
                else if (op_r == 2'd0 || (op_r == 2'd2 && idx_r == 3'd2)
                         || (op_r == 2'd3 && idx_r == 3'd3))
                begin
                  if (op_r == 2'd2) begin rd_r <= 1'b1; idx_r <= 3'd0; st_r <= H_START; end
                  else st_r <= H_STOP;
                end
                else
                begin
                  idx_r <= idx_r + 3'd1; sh_r <= cmd_byte(idx_r + 3'd1, rd_r); st_r <= H_BYTE;
                end
              end
            end
          end
          H_STOP:
          begin
            if (ph_r == 2'd0) sda_r <= 1'b0;
            if (ph_r == 2'd1) scl_r <= 1'b1;
            if (ph_r == 2'd2) sda_r <= 1'b1;
            if (ph_r == 2'd3) st_r <= H_IDLE;
          end
          default: st_r <= H_IDLE;
        endcase
      end
    end
  end
endmodule

/* dv/sep_link_monitor.sv */
// Purpose: wire checks on the serial eeprom link
// Assumes: one host and one device joined by sep_link_if
// Notes:   helper flops find start and stop on the wires
`timescale 1ns/100ps
module sep_link_monitor #(
  parameter int WRITE_CYCLES = 1000
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // link wires
  input wire logic scl_o_host,
  input wire logic scl_oe_n_host,
  input wire logic sda_o_host,
  input wire logic sda_oe_n_host,
  input wire logic sda_o_dev,
  input wire logic sda_oe_n_dev,
  input wire logic scl,
  input wire logic sda,
  // device status
  input wire logic o_busy
);
  logic        sda_q_r;
  logic        scl_q_r;
  logic [7:0]  since_stop_r;
  logic [15:0] busy_len_r;
  logic        start_w;
  logic        stop_w;
  // ==========================================================
  // start and stop finders
  assign start_w = scl & scl_q_r & sda_q_r & ~sda;
  assign stop_w  = scl & scl_q_r & ~sda_q_r & sda;
  always_ff @(posedge i_clk)
  begin
    sda_q_r <= sda;
    scl_q_r <= scl;
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      since_stop_r <= 8'hff;
    else if (stop_w)
      since_stop_r <= 8'h00;
    else if (since_stop_r != 8'hff)
      since_stop_r <= since_stop_r + 8'h01;
  end
  always_ff @(posedge i_clk)
  begin
    busy_len_r <= (i_rst_n && o_busy) ? busy_len_r + 16'h0001 : 16'h0000;
  end
  // ==========================================================
  // assertions
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  chk_scl_wired_and:
    assert property (scl == (scl_oe_n_host | scl_o_host)) else $error("scl level wrong");
  chk_sda_wired_and:
    assert property (sda == ((sda_oe_n_host | sda_o_host) & (sda_oe_n_dev | sda_o_dev)))
      else $error("sda level wrong");
  chk_dev_pull_low:
    assert property (!sda_oe_n_dev |-> !sda_o_dev) else $error("device drives high");
  chk_dev_change_low:
    assert property ($changed(sda_oe_n_dev) |-> !scl) else $error("device moved sda, scl high");
  chk_start_quiet:
    assert property (start_w |=> sda_oe_n_dev [*8]) else $error("device drove after start");
  chk_busy_no_ack:
    assert property (o_busy |-> sda_oe_n_dev) else $error("device acked while busy");
  chk_busy_after_stop:
    assert property ($rose(o_busy) |-> since_stop_r <= 8'h08) else $error("busy without stop");
  chk_busy_length:
    assert property ($fell(o_busy) |-> busy_len_r >= WRITE_CYCLES - 1
                     && busy_len_r <= WRITE_CYCLES + 1) else $error("write time wrong");
  chk_scl_high_time:
    assert property ($rose(scl) |-> scl [*3]) else $error("link clock high too short");
  cover property (start_w);
  cover property (stop_w);
  cover property ($rose(o_busy));
  cover property ($fell(sda_oe_n_dev));
endmodule

/* dv/tb_top.sv */
// Purpose: host and device end to end, polls and reads
// Assumes: straps 3'h5, write time shortened
// Notes:   expected bytes kept in a sparse memory
`timescale 1ns/100ps
module tb_top;
  localparam int         WC  = 600;
  localparam logic [2:0] SEL = 3'h5;
  logic        clk;
  logic        rst_n;
  logic        go;
  logic [1:0]  op;
  logic [2:0]  sel;
  logic [14:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  count;
  logic        ready;
  logic        rvalid;
  logic [7:0]  rdata;
  logic        nack;
  logic        busy;
  int          err_count;
  int          n_tests;
  logic [7:0]  got[$];
  logic [7:0]  mem[logic [14:0]];
  sep_link_if link ();
  sep_host sep_host_inst (.i_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_op(op), .i_sel(sel),
    .i_addr(addr), .i_wdata(wdata), .i_count(count), .o_ready(ready), .o_rvalid(rvalid),
    .o_rdata(rdata), .o_nack(nack), .link(link));
  sep_dev #(.WRITE_CYCLES(WC)) sep_dev_inst (.i_clk(clk), .i_rst_n(rst_n),
    .i_chip_select_bit_zero(1'b1), .i_chip_select_bit_one(1'b0),
    .i_chip_select_bit_two(1'b1), .o_busy(busy), .link(link));
  sep_link_monitor #(.WRITE_CYCLES(WC)) sep_link_monitor_inst (.i_clk(clk),
    .i_rst_n(rst_n), .scl_o_host(link.scl_o_host), .scl_oe_n_host(link.scl_oe_n_host),
    .sda_o_host(link.sda_o_host), .sda_oe_n_host(link.sda_oe_n_host),
    .sda_o_dev(link.sda_o_dev), .sda_oe_n_dev(link.sda_oe_n_dev), .scl(link.scl),
    .sda(link.sda), .o_busy(busy));
  initial clk = 1'b0;
  always #25 clk = ~clk;
  // ==========================================================
  // tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    if (seen !== exp)
      err_count++;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmd(input logic [1:0] o, input logic [2:0] s, input logic [14:0] a,
                     input logic [7:0] d, input logic [7:0] c);
    int n;
    got.delete();
    @(negedge clk);
    op = o;
    sel = s;
    addr = a;
    wdata = d;
    count = c;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    for (n = 0; n < 20000 && ready !== 1'b1; n++)
    begin
      if (rvalid === 1'b1)
        got.push_back(rdata);
      @(negedge clk);
    end
    if (n == 20000)
    begin
      check(16'h0000, 16'h0001);
      end_of_test();
    end
  endtask
  task automatic write_poll(input logic [14:0] a, input logic [7:0] d);
    int k;
    cmd(2'h3, SEL, a, d, 8'h01);
    mem[a] = d;
    for (k = 0; k < 16 && busy !== 1'b1; k++)
      @(negedge clk);
    check(busy, 1'b1);
    k = 0;
    cmd(2'h0, SEL, a, d, 8'h01);
    while (nack === 1'b1 && k < 50)
    begin
      cmd(2'h0, SEL, a, d, 8'h01);
      k++;
    end
    check(k > 0, 1'b1);
    check(nack, 1'b0);
  endtask
  task automatic rd(input logic [1:0] o, input logic [14:0] a, input logic [7:0] c,
                    input logic [14:0] e);
    logic [14:0] p;
    cmd(o, SEL, a, 8'h00, c);
    check(16'(got.size()), {8'h00, c});
    check(nack, 1'b0);
    p = e;
    foreach (got[i])
    begin
      check(got[i], mem[p]);
      p = p + 15'h0001;
    end
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    go = 1'b0;
    op = 2'h0;
    sel = SEL;
    addr = 15'h0000;
    wdata = 8'h00;
    count = 8'h01;
    rst_n = 1'b0;
    err_count = 0;
    n_tests = 0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    write_poll(15'h0123, 8'ha5);
    write_poll(15'h7fff, 8'h3c);
    write_poll(15'h0000, 8'hc3);
    write_poll(15'h0001, 8'h5a);
    write_poll(15'h0002, 8'h96);
    rd(2'h2, 15'h7fff, 8'h03, 15'h7fff);
    rd(2'h2, 15'h7fff, 8'h02, 15'h7fff);
    cmd(2'h2, 3'h2, 15'h0123, 8'h00, 8'h01);
    check(nack, 1'b1);
    check(16'(got.size()), 16'h0000);
    rd(2'h1, 15'h0000, 8'h01, 15'h0001);
    rd(2'h1, 15'h0000, 8'h01, 15'h0002);
    rd(2'h2, 15'h0123, 8'h01, 15'h0123);
    cmd(2'h0, SEL, 15'h0000, 8'h00, 8'h01);
    check(nack, 1'b0);
    end_of_test();
  end
endmodule
